// ---- verilog/smwg_pkg.sv ----
// Shared constants for the serial memory write guard: timing, control register
// layout, reset values and the controller's state encoding.
// Assumes a 10 MHz system clock; every count below is derived from that rate.
package smwg_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned MCLK_KHZ      = 10000;
	localparam int unsigned WD_LONG_MS    = 1400;
	localparam int unsigned WD_MID_MS     = 600;
	localparam int unsigned WD_SHORT_MS   = 200;
	localparam int unsigned WD_HOLD_MS    = 200;
	localparam int unsigned NV_WRITE_MS   = 10;
	localparam int unsigned WD_LONG_CYC   = WD_LONG_MS * MCLK_KHZ;
	localparam int unsigned WD_MID_CYC    = WD_MID_MS * MCLK_KHZ;
	localparam int unsigned WD_SHORT_CYC  = WD_SHORT_MS * MCLK_KHZ;
	localparam int unsigned WD_HOLD_CYC   = WD_HOLD_MS * MCLK_KHZ;
	localparam int unsigned NV_WRITE_CYC  = NV_WRITE_MS * MCLK_KHZ;
	localparam int unsigned TMR_W         = 24;

	// ----------------------------------------------------------------
	// Array and addressing
	// ----------------------------------------------------------------
	localparam int unsigned MEM_DEPTH     = 2048;
	localparam logic [15:0] CTRL_ADDR     = 16'hffff;
	localparam logic [4:0]  DEV_TYPE      = 5'h14;
	localparam logic [15:0] PROT_1PG_LIM  = 16'h0040;
	localparam logic [15:0] PROT_2PG_LIM  = 16'h0080;
	localparam logic [15:0] PROT_4PG_LIM  = 16'h0100;
	localparam logic [15:0] PROT_8PG_LIM  = 16'h0200;

	// ----------------------------------------------------------------
	// Control register layout and values
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_HW_PROTECT_ENABLE     = 7;
	localparam int unsigned CTRL_WD_HI    = 6;
	localparam int unsigned CTRL_WD_LO    = 5;
	localparam int unsigned CTRL_BP1      = 4;
	localparam int unsigned CTRL_BP0      = 3;
	localparam int unsigned CTRL_REGISTER_WRITE_LATCH     = 2;
	localparam int unsigned CTRL_WEL      = 1;
	localparam int unsigned CTRL_BP2      = 0;
	localparam logic [7:0]  CTRL_WEL_CLR  = 8'h00;
	localparam logic [7:0]  CTRL_WEL_SET  = 8'h02;
	localparam logic [7:0]  CTRL_REGISTER_WRITE_LATCH_SET = 8'h06;
	localparam logic [1:0]  WD_SEL_LONG   = 2'h0;
	localparam logic [1:0]  WD_SEL_MID    = 2'h1;
	localparam logic [1:0]  WD_SEL_SHORT  = 2'h2;
	localparam logic [1:0]  WD_SEL_OFF    = 2'h3;
	localparam logic [1:0]  WD_RST        = WD_SEL_OFF;
	localparam logic [2:0]  BP_RST        = 3'h0;
	localparam logic        HW_PROTECT_ENABLE_RST      = 1'b0;

	typedef enum logic [2:0] {
		ST_IDLE, ST_DEV, ST_AHI, ST_ALO, ST_WDATA, ST_RDATA, ST_BUSY
	} smwg_state_e;

	// Address range locked by each block protect setting.
	function automatic logic blk_protected(input logic [2:0] bp, input logic [15:0] a);
		case (bp)
			3'h3: return 1'b1;
			3'h4: return a < PROT_1PG_LIM;
			3'h5: return a < PROT_2PG_LIM;
			3'h6: return a < PROT_4PG_LIM;
			3'h7: return a < PROT_8PG_LIM;
			default: return 1'b0;
		endcase
	endfunction

endpackage

// ---- verilog/smwg_sync.sv ----
// Two-stage synchroniser for a group of pins.
// Assumes the inputs are asynchronous to mclk; only the second stage is read.
`timescale 1ns/1ps
module smwg_sync #(
	parameter int unsigned   W       = 1,
	parameter logic [W-1:0]  RST_VAL = '0
)(
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         nrst,
	// Pins in, synchronised copy out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} smwg_sync_s;

	smwg_sync_s s;
	smwg_sync_s next_s;

	always_comb begin
		next_s.meta = d;
		next_s.sync = s.meta;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s.meta <= RST_VAL;
			s.sync <= RST_VAL;
		end else begin
			s <= next_s;
		end
	end

	assign q = s.sync;
endmodule

// ---- verilog/smwg_watchdog.sv ----
// Watchdog: restarted by each bus start outside the reset hold, raises the supervisor reset on timeout.
// Assumes kick is a one-cycle pulse on mclk; the period code comes from the
// control register.
`timescale 1ns/1ps
module smwg_watchdog #(
	parameter int unsigned LONG_CYC  = smwg_pkg::WD_LONG_CYC,
	parameter int unsigned MID_CYC   = smwg_pkg::WD_MID_CYC,
	parameter int unsigned SHORT_CYC = smwg_pkg::WD_SHORT_CYC,
	parameter int unsigned HOLD_CYC  = smwg_pkg::WD_HOLD_CYC
)(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       nrst,
	// Control
	input  wire logic       kick,
	input  wire logic [1:0] period,
	// Supervisor reset
	output logic            wd_reset
);
	import smwg_pkg::*;

	typedef struct packed {
		logic [TMR_W-1:0] cnt;
		logic             active;
	} smwg_wd_s;

	smwg_wd_s s;
	smwg_wd_s next_s;

	function automatic logic [TMR_W-1:0] wd_limit(input logic [1:0] sel);
		case (sel)
			WD_SEL_LONG: return TMR_W'(LONG_CYC - 1);
			WD_SEL_MID:  return TMR_W'(MID_CYC - 1);
			default:     return TMR_W'(SHORT_CYC - 1);
		endcase
	endfunction

	// A start during the reset hold is not counted; the hold always runs out.
	always_comb begin
		next_s = s;
		if (s.active) begin
			next_s.cnt = s.cnt + 1'b1;
			if (s.cnt == TMR_W'(HOLD_CYC - 1)) begin
				next_s.active = 1'b0;
				next_s.cnt    = '0;
			end
		end else if (kick || period == WD_SEL_OFF) begin
			next_s.cnt = '0;
		end else if (s.cnt >= wd_limit(period)) begin
			// A shorter period chosen mid-count fires at once rather than after a wrap.
			next_s.active = 1'b1;
			next_s.cnt    = '0;
		end else begin
			next_s.cnt = s.cnt + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign wd_reset = s.active;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking wd_cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	kick_restart_a: assert property (
		kick && !s.active |=> s.cnt == '0 && !wd_reset)
		else $error("start did not restart the watchdog");
	period_expire_a: assert property (
		!s.active && !kick && period != WD_SEL_OFF && s.cnt >= wd_limit(period)
		|=> wd_reset)
		else $error("watchdog timeout did not raise reset");
	wd_off_a: assert property (
		!s.active && period == WD_SEL_OFF |=> !wd_reset)
		else $error("disabled watchdog raised reset");
	cov_wd_fire: cover property (!wd_reset ##1 wd_reset);
endmodule

// ---- verilog/smwg_top.sv ----
// Two-wire slave front end with the write protection logic of the memory.
// Assumes scl, sda_in, wp and the select pins are asynchronous to mclk; the
// open-drain sda pin is resolved outside from sda_out and sda_oe.
//
// Contract
// - Write enable latch clear at reset; writes then ignored, data byte not acknowledged; control 02h and 00h still accepted here.
// - Control write 02h sets, 00h clears the latch; no busy period follows.
// - Watchdog field selects 1.4 s, 600 ms, 200 ms or disabled.
// - Hardware protection active only with protect pin and enable bit high.
// - Hardware protection blocks protected array writes and block protect changes.
// - Enable bit cannot be written while pin and bit are both high.
// - First step: a whole write of 02h, volatile, immediate.
// - Second step: a whole write of 06h sets both latches.
// - Third write stores control bits in a timed cycle, clearing register latch as the cycle starts; here only with data bit 2 clear.
// - A second data byte to the control register aborts with a not-acknowledge.
// - Reads between the sequence steps leave the sequence intact.
// - Register latch cleared only by the stored write, reset or protected attempt.
// - Data changes only with clock low; other changes are start or stop.
// - Nothing is answered before a start condition.
// - Each transfer ends with a stop; a stop returns to standby.
// - Receiver pulls data low in the ninth clock to acknowledge.
// - Acknowledge matching slave address and both address bytes; the first data byte only when the write is accepted.
// - Reads send eight bits, sample acknowledge, continue only while acknowledged.
// - Byte write cycle starts at stop; inputs ignored and data released meanwhile.
// - A write into a protected block is not acknowledged.
// - Control register sits at address ffffh for writes and reads.
// - Control bits 7..0: enable, period hi, lo, block 1, 0, latches, block 2.
// - Each start restarts the watchdog; timeout raises the reset output; starts during the reset hold are ignored here.
`timescale 1ns/1ps
module smwg_top #(
	parameter int unsigned NV_CYCLES = smwg_pkg::NV_WRITE_CYC,
	parameter int unsigned WD_LONG   = smwg_pkg::WD_LONG_CYC,
	parameter int unsigned WD_MID    = smwg_pkg::WD_MID_CYC,
	parameter int unsigned WD_SHORT  = smwg_pkg::WD_SHORT_CYC,
	parameter int unsigned WD_HOLD   = smwg_pkg::WD_HOLD_CYC,
	parameter int unsigned DEPTH     = smwg_pkg::MEM_DEPTH
)(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       nrst,
	// Two-wire bus
	input  wire logic       scl,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// Straps and protect pin
	input  wire logic       wp,
	input  wire logic [1:0] dev_sel,
	// Status
	output logic            sup_reset,
	output logic            nv_busy
);
	import smwg_pkg::*;

	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		smwg_state_e st;
		logic        scl_q;
		logic        sda_q;
		logic [3:0]  bitcnt;
		logic        ackph;
		logic        mack;
		logic        is_read;
		logic [7:0]  shreg;
		logic        sda_oe;
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic [1:0]  dcount;
		logic        pend;
		logic        write_enable_latch;
		logic        register_write_latch;
		logic        hw_protect_enable;
		logic [1:0]  wd;
		logic [2:0]  bp;
		logic [TMR_W-1:0] tmr;
	} smwg_top_s;

	smwg_top_s s;
	smwg_top_s next_s;

	logic [4:0]  pins_s;
	logic        scl_s;
	logic        sda_s;
	logic        wp_s;
	logic [1:0]  sel_s;
	logic        ev_rise;
	logic        ev_fall;
	logic        ev_start;
	logic        ev_stop;
	logic        fall8;
	logic        commit;
	logic        hwp;
	logic        is_ctrl;
	logic        dev_match;
	logic        mem_we;
	logic [7:0]  ctrl_val;
	logic [7:0]  rd_now;
	logic [7:0]  rd_inc;
	logic [15:0] addr_inc;
	logic [7:0]  mem [DEPTH];

	// ----------------------------------------------------------------
	// Pin synchronisers and watchdog
	// ----------------------------------------------------------------
	smwg_sync #(.W(5), .RST_VAL(5'h18)) u_sync (
		.mclk (mclk),
		.nrst (nrst),
		.d    ({scl, sda_in, wp, dev_sel}),
		.q    (pins_s)
	);

	assign scl_s = pins_s[4];
	assign sda_s = pins_s[3];
	assign wp_s  = pins_s[2];
	assign sel_s = pins_s[1:0];

	smwg_watchdog #(
		.LONG_CYC  (WD_LONG),
		.MID_CYC   (WD_MID),
		.SHORT_CYC (WD_SHORT),
		.HOLD_CYC  (WD_HOLD)
	) u_wd (
		.mclk     (mclk),
		.nrst     (nrst),
		.kick     (ev_start),
		.period   (s.wd),
		.wd_reset (sup_reset)
	);

	// ----------------------------------------------------------------
	// Bus events and decode
	// ----------------------------------------------------------------
	// Any data edge while the clock stays high is a start or a stop.
	assign ev_rise   = scl_s && !s.scl_q;
	assign ev_fall   = !scl_s && s.scl_q;
	assign ev_start  = scl_s && s.scl_q && s.sda_q && !sda_s;
	assign ev_stop   = scl_s && s.scl_q && !s.sda_q && sda_s;
	assign fall8     = ev_fall && !s.ackph && s.bitcnt == 4'h8;
	assign hwp       = wp_s && s.hw_protect_enable;
	assign is_ctrl   = s.addr == CTRL_ADDR;
	assign dev_match = s.shreg[7:3] == DEV_TYPE && s.shreg[2:1] == sel_s;
	// The stop that closes a write follows one clock rise after the ack bit.
	assign commit    = s.st == ST_WDATA && s.pend && s.dcount == 2'h1
		&& !s.ackph && s.bitcnt <= 4'h1;
	assign ctrl_val  = {s.hw_protect_enable, s.wd, s.bp[1], s.bp[0], s.register_write_latch, s.write_enable_latch, s.bp[2]};
	assign addr_inc  = s.addr + 16'h0001;
	assign rd_now    = rd_byte(s.addr);
	assign rd_inc    = rd_byte(addr_inc);

	function automatic logic [7:0] rd_byte(input logic [15:0] a);
		if (a == CTRL_ADDR) begin
			return ctrl_val;
		end
		return mem[a[AW-1:0]];
	endfunction

	// ----------------------------------------------------------------
	// Controller
	// ----------------------------------------------------------------
	always_comb begin
		next_s       = s;
		mem_we       = 1'b0;
		next_s.scl_q = scl_s;
		next_s.sda_q = sda_s;
		if (s.st == ST_BUSY) begin
			next_s.sda_oe = 1'b0;
			next_s.tmr    = s.tmr + 1'b1;
			if (s.tmr == TMR_W'(NV_CYCLES - 1)) begin
				next_s.st = ST_IDLE;
			end
		end else if (ev_start) begin
			next_s.st      = ST_DEV;
			next_s.bitcnt  = '0;
			next_s.ackph   = 1'b0;
			next_s.sda_oe  = 1'b0;
			next_s.dcount  = '0;
			next_s.pend    = 1'b0;
			next_s.is_read = 1'b0;
		end else if (ev_stop) begin
			next_s.st     = ST_IDLE;
			next_s.sda_oe = 1'b0;
			next_s.bitcnt = '0;
			next_s.ackph  = 1'b0;
			if (commit && is_ctrl && s.register_write_latch) begin
				if (!s.wdata[CTRL_REGISTER_WRITE_LATCH]) begin
					next_s.wd   = s.wdata[CTRL_WD_HI:CTRL_WD_LO];
					next_s.write_enable_latch  = s.wdata[CTRL_WEL];
					next_s.register_write_latch = 1'b0;
					next_s.st   = ST_BUSY;
					next_s.tmr  = '0;
					if (!hwp) begin
						next_s.bp   = {s.wdata[CTRL_BP2], s.wdata[CTRL_BP1], s.wdata[CTRL_BP0]};
						next_s.hw_protect_enable = s.wdata[CTRL_HW_PROTECT_ENABLE];
					end
				end
			end else if (commit && is_ctrl) begin
				if (s.wdata == CTRL_WEL_SET) begin
					next_s.write_enable_latch = 1'b1;
				end else if (s.wdata == CTRL_WEL_CLR) begin
					next_s.write_enable_latch = 1'b0;
				end else if (s.wdata == CTRL_REGISTER_WRITE_LATCH_SET && s.write_enable_latch) begin
					next_s.register_write_latch = 1'b1;
					next_s.write_enable_latch  = 1'b1;
				end
			end else if (commit) begin
				mem_we     = 1'b1;
				next_s.st  = ST_BUSY;
				next_s.tmr = '0;
			end
		end else if (s.st != ST_IDLE) begin
			if (ev_rise) begin
				if (!s.ackph && s.bitcnt < 4'h8) begin
					next_s.shreg  = {s.shreg[6:0], sda_s};
					next_s.bitcnt = s.bitcnt + 4'h1;
				end else if (s.ackph) begin
					next_s.mack = sda_s;
				end
			end else if (fall8) begin
				next_s.ackph = 1'b1;
				next_s.sda_oe = 1'b0;
				case (s.st)
					ST_DEV: begin
						if (dev_match) begin
							next_s.sda_oe  = 1'b1;
							next_s.is_read = s.shreg[0];
							next_s.st      = s.shreg[0] ? ST_RDATA : ST_AHI;
						end else begin
							next_s.st = ST_IDLE;
						end
					end
					ST_AHI: begin
						next_s.sda_oe     = 1'b1;
						next_s.addr[15:8] = s.shreg;
						next_s.st         = ST_ALO;
					end
					ST_ALO: begin
						next_s.sda_oe    = 1'b1;
						next_s.addr[7:0] = s.shreg;
						next_s.st        = ST_WDATA;
					end
					ST_WDATA: begin
						if (s.dcount != 2'h3) begin
							next_s.dcount = s.dcount + 2'h1;
						end
						next_s.pend = 1'b0;
						if (s.dcount == 2'h0) begin
							next_s.wdata = s.shreg;
							if (is_ctrl) begin
								// Latch-only codes must pass with the latch clear,
								// or the latch could never be set.
								next_s.pend = s.write_enable_latch || (!s.register_write_latch
									&& (s.shreg == CTRL_WEL_SET || s.shreg == CTRL_WEL_CLR));
							end else if (blk_protected(s.bp, s.addr)) begin
								next_s.register_write_latch = 1'b0;
							end else begin
								next_s.pend = s.write_enable_latch;
							end
							next_s.sda_oe = next_s.pend;
						end
					end
					default: begin
						next_s.sda_oe = 1'b0;
					end
				endcase
			end else if (ev_fall && s.ackph) begin
				next_s.ackph  = 1'b0;
				next_s.bitcnt = '0;
				next_s.sda_oe = 1'b0;
				if (s.is_read) begin
					next_s.is_read = 1'b0;
					next_s.shreg   = rd_now;
					next_s.sda_oe  = !rd_now[7];
				end else if (s.st == ST_RDATA) begin
					// A control register read always ends after one byte.
					if (!s.mack && !is_ctrl) begin
						next_s.addr   = addr_inc;
						next_s.shreg  = rd_inc;
						next_s.sda_oe = !rd_inc[7];
					end else begin
						next_s.st = ST_IDLE;
					end
				end
			end else if (ev_fall && s.st == ST_RDATA && s.bitcnt != 4'h0) begin
				next_s.sda_oe = !s.shreg[7];
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s       <= '0;
			s.scl_q <= 1'b1;
			s.sda_q <= 1'b1;
			s.wd    <= WD_RST;
			s.bp    <= BP_RST;
			s.hw_protect_enable  <= HW_PROTECT_ENABLE_RST;
		end else begin
			s <= next_s;
		end
	end

	always_ff @(posedge mclk) begin
		if (mem_we) begin
			mem[s.addr[AW-1:0]] <= s.wdata;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = s.sda_oe;
	assign nv_busy = s.st == ST_BUSY;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking top_cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	wel_nack_a: assert property (
		fall8 && s.st == ST_WDATA && !s.write_enable_latch && !is_ctrl |=> !sda_oe)
		else $error("data byte acknowledged with latch clear");
	latch_set_a: assert property (
		ev_stop && commit && is_ctrl && !s.register_write_latch && s.wdata == CTRL_WEL_SET
		|=> s.write_enable_latch && s.st == ST_IDLE)
		else $error("latch set write misbehaved");
	nv_cycle_a: assert property (
		ev_stop && commit && is_ctrl && s.register_write_latch && !s.wdata[CTRL_REGISTER_WRITE_LATCH]
		|=> !s.register_write_latch && nv_busy [*8])
		else $error("control store did not start a cycle");
	register_write_latch_keep_a: assert property (
		ev_stop && commit && is_ctrl && s.register_write_latch && s.wdata[CTRL_REGISTER_WRITE_LATCH]
		|=> s.register_write_latch && $stable(s.bp) && $stable(s.wd) && !nv_busy)
		else $error("bit 2 write changed control bits");
	hwp_bp_a: assert property (
		hwp |=> s.bp == $past(s.bp))
		else $error("block protect changed under hardware protection");
	hw_protect_enable_lock_a: assert property (
		wp_s && s.hw_protect_enable |=> s.hw_protect_enable)
		else $error("protect enable cleared while locked");
	extra_nack_a: assert property (
		fall8 && s.st == ST_WDATA && s.dcount != 2'h0 |=> !sda_oe && !s.pend)
		else $error("extra data byte acknowledged");
	busy_quiet_a: assert property (
		nv_busy |-> !sda_oe)
		else $error("data driven during write cycle");
	prot_nack_a: assert property (
		fall8 && s.st == ST_WDATA && s.dcount == 2'h0 && !is_ctrl
		&& blk_protected(s.bp, s.addr) |=> !sda_oe && !s.register_write_latch)
		else $error("protected write acknowledged");
	addr_ack_a: assert property (
		fall8 && s.st == ST_DEV && dev_match |=> sda_oe)
		else $error("matching slave address not acknowledged");

	cov_ctrl_store: cover property (ev_stop && commit && is_ctrl && s.register_write_latch);
	cov_array_write: cover property (mem_we ##1 nv_busy);
	cov_read_ack: cover property (s.st == ST_RDATA && ev_fall && s.ackph && !s.mack);
endmodule

// ---- verif/smwg_master_model.sv ----
// Bit-banging two-wire bus master standing on the far side of the slave.
// Assumes the bench resolves the open-drain data wire and feeds it back on sda.
`timescale 1ns/1ps
module smwg_master_model (
	// Pacing clock
	input  wire logic mclk,
	// Resolved data wire
	input  wire logic sda,
	// Master outputs; a high sda_drv releases the wire to its pull-up
	output logic      scl,
	output logic      sda_drv
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// Data only moves while the clock is low.
	task automatic bit_io(input logic b, output logic s);
		scl = 1'b0;
		sda_drv = b;
		tick(4);
		scl = 1'b1;
		tick(2);
		s = sda;
		tick(2);
	endtask

	task automatic start();
		scl = 1'b0;
		tick(4);
		sda_drv = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(4);
		sda_drv = 1'b0;
		tick(4);
	endtask

	// Stop only after the wire is ours again.
	task automatic stop();
		scl = 1'b0;
		sda_drv = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(4);
		sda_drv = 1'b1;
		tick(4);
	endtask

	// Ninth clock released so the slave can pull low.
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ack = !s;
	endtask

	task automatic rbyte(input logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(!mack, s);
	endtask
endmodule

// ---- verif/smwg_top_tb_top.sv ----
// Self-checking bench for the write guard, driving the bus through the master model.
// Assumes the design counts are shortened through its parameters below.
`timescale 1ns/1ps
module smwg_top_tb_top;
	import smwg_pkg::*;
	localparam int NV_C = 20;
	localparam int WD_L = 400;
	localparam int WD_M = 300;
	localparam int WD_S = 200;
	localparam int WD_H = 50;
	logic        mclk;
	logic        nrst;
	logic        wp;
	logic [1:0]  dev_sel;
	logic [7:0]  dev_w;
	logic        scl;
	logic        sda_drv;
	logic        sda_out;
	logic        sda_oe;
	logic        sup_reset;
	logic        nv_busy;
	logic        sda_wire;
	logic        k;
	logic        ak;
	logic        wd_seen = 1'b0;
	logic [7:0]  d;
	logic [7:0]  r;
	logic [15:0] a;
	logic [31:0] seed = 32'he3c0;
	int          bad_count = 0;
	int          check_count = 0;
	int          cyc = 0;

	always #50 mclk = ~mclk;
	// Open drain with pull-up: either party may pull low.
	assign sda_wire = sda_drv & (sda_oe ? sda_out : 1'b1);

	smwg_top #(.NV_CYCLES(NV_C), .WD_LONG(WD_L), .WD_MID(WD_M), .WD_SHORT(WD_S),
		.WD_HOLD(WD_H)) smwg_top_inst (
		.mclk(mclk), .nrst(nrst), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out),
		.sda_oe(sda_oe), .wp(wp), .dev_sel(dev_sel), .sup_reset(sup_reset),
		.nv_busy(nv_busy));
	smwg_master_model m (.mclk(mclk), .sda(sda_wire), .scl(scl), .sda_drv(sda_drv));

	always @(posedge mclk) begin
		cyc++;
		if (sup_reset === 1'b1) begin
			wd_seen = 1'b1;
		end
		if (cyc == 60000) begin
			bad_count++;
			print_verdict();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic addr_phase(input logic [15:0] ad);
		logic k0;
		logic k1;
		logic k2;
		m.start();
		m.wbyte(dev_w, k0);
		m.wbyte(ad[15:8], k1);
		m.wbyte(ad[7:0], k2);
		check("addr ack", {k0, k1, k2}, 3'h7);
	endtask

	task automatic wr(input logic [15:0] ad, input logic [7:0] dd, input int nb);
		addr_phase(ad);
		repeat (nb) m.wbyte(dd, ak);
		m.stop();
	endtask

	task automatic rd(input logic [15:0] ad, output logic [7:0] dd);
		logic kk;
		addr_phase(ad);
		m.start();
		m.wbyte(dev_w | 8'h01, kk);
		m.rbyte(1'b0, dd);
		m.stop();
	endtask

	// Busy is looked at shortly after the stop, then waited out under a bound.
	task automatic fin(input logic e);
		int w;
		m.tick(4);
		check("nv_busy", nv_busy, e);
		w = 0;
		while (nv_busy !== 1'b0 && w < 200) begin
			m.tick(1);
			w++;
		end
	endtask

	// The latch steps always precede the stored write.
	task automatic seq3(input logic [7:0] v, input logic e);
		wr(16'hffff, CTRL_WEL_SET, 1);
		fin(1'b0);
		wr(16'hffff, CTRL_REGISTER_WRITE_LATCH_SET, 1);
		fin(1'b0);
		wr(16'hffff, v, 1);
		fin(e);
	endtask

	task automatic wait_wd(input logic v);
		int w;
		w = 0;
		while (sup_reset !== v && w < 1000) begin
			m.tick(1);
			w++;
		end
		check("wd level", sup_reset, v);
	endtask

	// Reset pulse width and quiet time of the watchdog, counted in mclk cycles.
	task automatic wd_period(input logic [1:0] code, input int per);
		int t0;
		int t1;
		seq3({1'b0, code, 5'h02}, 1'b1);
		wait_wd(1'b0);
		wait_wd(1'b1);
		t0 = cyc;
		wait_wd(1'b0);
		t1 = cyc;
		wait_wd(1'b1);
		check("wd hold", 16'(t1 - t0), 16'(WD_H));
		check("wd period", 16'(cyc - t1), 16'(per));
		$display("test watchdog %0d done", code);
	endtask

	task automatic rd_ctl(input string s, input logic [7:0] e);
		rd(16'hffff, d);
		check(s, d, e);
		$display("test %s done", s);
	endtask

	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		wp = 1'b0;
		seed = xs(seed);
		dev_sel = seed[1:0];
		dev_w = {DEV_TYPE, seed[1:0], 1'b0};
		repeat (4) @(posedge mclk);
		#1;
		nrst = 1'b1;
		m.tick(6);
		check("oe idle", {sda_oe, nv_busy, sup_reset}, 3'h0);
		m.wbyte(dev_w, k);
		check("no start", k, 1'b0);
		rd_ctl("reset", 8'h60);
		wr(16'h0300, 8'h5a, 1);
		check("wel clear", ak, 1'b0);
		fin(1'b0);
		m.start();
		m.wbyte(dev_w ^ 8'h02, k);
		m.stop();
		check("bad sel", k, 1'b0);
		wr(16'hffff, CTRL_WEL_SET, 1);
		fin(1'b0);
		rd_ctl("wel set", 8'h62);
		wr(16'hffff, CTRL_WEL_CLR, 1);
		fin(1'b0);
		rd_ctl("wel clr", 8'h60);
		wr(16'hffff, CTRL_WEL_SET, 1);
		fin(1'b0);
		rd_ctl("mid read", 8'h62);
		wr(16'hffff, CTRL_REGISTER_WRITE_LATCH_SET, 1);
		fin(1'b0);
		rd_ctl("both", 8'h66);
		wr(16'hffff, 8'h73, 1);
		fin(1'b1);
		rd_ctl("stored", 8'h73);
		seq3(8'h06, 1'b0);
		rd_ctl("kept", 8'h77);
		wr(16'h0050, 8'ha5, 1);
		check("prot ack", ak, 1'b0);
		fin(1'b0);
		rd_ctl("register_write_latch lost", 8'h73);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			a = 16'h0100 + 16'(seed[15:0] % 16'h0700);
			r = seed[23:16];
			dev_sel = seed[25:24];
			dev_w = {DEV_TYPE, seed[25:24], 1'b0};
			wr(a, r, 1);
			check("arr ack", ak, 1'b1);
			fin(1'b1);
			rd(a, d);
			check("arr data", d, r);
		end
		$display("test array done");
		wp = 1'b1;
		seq3(8'hf3, 1'b1);
		rd_ctl("hw_protect_enable set", 8'hf3);
		seq3(8'h62, 1'b1);
		rd_ctl("hw locked", 8'hf3);
		wr(16'h0020, 8'h11, 1);
		check("hw prot", ak, 1'b0);
		fin(1'b0);
		wr(16'h0400, 8'h3c, 1);
		check("hw free", ak, 1'b1);
		fin(1'b1);
		wp = 1'b0;
		seq3(8'h62, 1'b1);
		rd_ctl("wp low", 8'h62);
		check("wd off", wd_seen, 1'b0);
		wd_period(2'h0, WD_L);
		wd_period(2'h1, WD_M);
		wd_period(2'h2, WD_S);
		wr(16'hffff, CTRL_WEL_SET, 1);
		fin(1'b0);
		wr(16'hffff, CTRL_REGISTER_WRITE_LATCH_SET, 1);
		fin(1'b0);
		wr(16'hffff, 8'h42, 2);
		check("extra byte", ak, 1'b0);
		$display("test abort done");
		nrst = 1'b0;
		m.tick(2);
		nrst = 1'b1;
		m.tick(6);
		check("rst idle", {sda_oe, nv_busy, sup_reset}, 3'h0);
		rd_ctl("power cycle", 8'h60);
		print_verdict();
	end
endmodule
